// ==== hdl/rra_pair_match.sv ====
/*
  Compares one source/destination pair against all configured pairs.
  Assumes pairs arrive packed, pair 0 in the low byte.
*/
`timescale 1ns/1ns
`default_nettype none
module rra_pair_match (
  // Configured pairs
  input wire logic [rra_pkg::PAIR_N*8-1:0] snd_in,
  input wire logic [rra_pkg::PAIR_N*8-1:0] tgt_in,
  // Pair to check
  input wire logic [7:0] src_in,
  input wire logic [7:0] dst_in,
  // Result
  output logic hit_out
);
  import rra_pkg::*;

  logic [PAIR_N-1:0] hit_vec; // One bit per configured pair

  // Both addresses must match the same pair
  for (genvar p = 0; p < PAIR_N; p++) begin : g_pair
    assign hit_vec[p] = (snd_in[p*8 +: 8] == src_in) &&
                        (tgt_in[p*8 +: 8] == dst_in);
  end

  assign hit_out = |hit_vec;
endmodule : rra_pair_match
`default_nettype wire

// ==== hdl/rra_pkg.sv ====
/*
  Shared constants for the radio repeater address router: register
  numbers, storage slots, reset values, mode codes and delay-line layout.
  Assumes nothing of its surroundings; every design file imports it.
*/
package rra_pkg;
  // Widths and counts
  localparam int ADDR_W = 8;
  localparam int KEY_W = 24;
  localparam int PAIR_N = 4;
  localparam int SLOT_N = 10;
  localparam int RX_DELAY = 2;
  localparam int DLY_W = 11;

  // Register numbers in command mode
  localparam logic [7:0] REG_LOCAL = 8'h5a;
  localparam logic [7:0] REG_DEST = 8'h5b;
  localparam logic [7:0] REG_P1_SND = 8'h5c;
  localparam logic [7:0] REG_P1_TGT = 8'h5d;
  localparam logic [7:0] REG_P2_SND = 8'h5e;
  localparam logic [7:0] REG_P2_TGT = 8'h5f;
  localparam logic [7:0] REG_P3_SND = 8'h60;
  localparam logic [7:0] REG_P4_TGT = 8'h61;
  localparam logic [7:0] REG_P3_TGT = 8'h62;
  localparam logic [7:0] REG_P4_SND = 8'h63;
  localparam logic [7:0] REG_STATUS = 8'h64;

  // Storage slots: local, destination, then sender/target per pair
  localparam logic [3:0] SLOT_LOCAL = 4'h0;
  localparam logic [3:0] SLOT_DEST = 4'h1;
  localparam int SLOT_PAIR0 = 2;

  // Reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [KEY_W-1:0] KEY_OFF = 24'h000000;

  // Operating modes
  localparam logic [1:0] MODE_TRANSP = 2'h0;
  localparam logic [1:0] MODE_MODBUS = 2'h1;
  localparam logic [1:0] MODE_MIRROR = 2'h2;
  localparam logic [1:0] MODE_ETHERNET = 2'h3;

  // Delay-line entry: {tag, last, data}
  localparam int DLY_LAST = 8;
  localparam int DLY_TAG = 9;
  localparam logic [1:0] TAG_NONE = 2'h0;
  localparam logic [1:0] TAG_SER = 2'h1;
  localparam logic [1:0] TAG_RLY = 2'h2;

  // Relay header steps
  localparam logic [1:0] RL_NONE = 2'h0;
  localparam logic [1:0] RL_SRC = 2'h1;
  localparam logic [1:0] RL_DST = 2'h2;
endpackage : rra_pkg

// ==== hdl/rra_router.sv ====
/*
  Address router and repeater for radio frames, with frame scrambling.
  Assumes byte streams synchronous to clk_in, at most one byte per cycle,
  and that the serial and radio sinks always accept what is offered.
*/
`timescale 1ns/1ns
`default_nettype none
module rra_router (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command-mode register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_num_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // Operating configuration
  input wire logic route_en_in,
  input wire logic [1:0] op_mode_in,
  input wire logic enc_en_in,
  input wire logic [rra_pkg::KEY_W-1:0] key_in,
  // Serial host data to send by radio
  input wire logic host_valid_in,
  input wire logic [7:0] host_data_in,
  input wire logic host_last_in,
  output logic host_ready_out,
  // Radio receive stream
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_last_in,
  // Radio transmit stream
  output logic rad_valid_out,
  output logic [7:0] rad_data_out,
  output logic rad_last_out,
  // Serial output stream
  output logic ser_valid_out,
  output logic [7:0] ser_data_out,
  output logic ser_last_out
);
  import rra_pkg::*;

  typedef enum logic [2:0] {RX_IDLE, RX_DST, RX_SER, RX_RLY, RX_DROP}
    rra_rx_t;
  typedef enum logic [1:0] {O_IDLE, O_SRC, O_DST, O_DATA} rra_org_t;

  // Register number to storage slot; bit 4 marks a mapped slot
  function automatic logic [4:0] reg_slot(input logic [7:0] num);
    case (num)
      REG_LOCAL: reg_slot = 5'h10;
      REG_DEST: reg_slot = 5'h11;
      REG_P1_SND: reg_slot = 5'h12;
      REG_P1_TGT: reg_slot = 5'h13;
      REG_P2_SND: reg_slot = 5'h14;
      REG_P2_TGT: reg_slot = 5'h15;
      REG_P3_SND: reg_slot = 5'h16;
      REG_P3_TGT: reg_slot = 5'h17;
      REG_P4_SND: reg_slot = 5'h18;
      REG_P4_TGT: reg_slot = 5'h19;
      default: reg_slot = 5'h00;
    endcase
  endfunction : reg_slot

  logic [7:0] addr_q [SLOT_N]; // Address registers
  logic [7:0] local_addr; // Own address
  logic [7:0] dest_addr; // Final destination for originated frames
  logic [PAIR_N*8-1:0] snd_vec; // Pair senders, packed
  logic [PAIR_N*8-1:0] tgt_vec; // Pair targets, packed
  logic [4:0] wr_slot; // Decoded write slot
  logic [4:0] rd_slot; // Decoded read slot
  logic [7:0] status; // Live state for readback
  logic [7:0] rd_value; // Read mux result
  logic route_active; // Routing applies in this mode
  logic enc_on; // Scrambling applies

  // Register file

  assign wr_slot = reg_slot(reg_num_in);
  assign rd_slot = reg_slot(reg_num_in);
  assign local_addr = addr_q[SLOT_LOCAL];
  assign dest_addr = addr_q[SLOT_DEST];

  // Pack pairs for the matcher
  for (genvar p = 0; p < PAIR_N; p++) begin : g_pack
    assign snd_vec[p*8 +: 8] = addr_q[SLOT_PAIR0 + 2*p];
    assign tgt_vec[p*8 +: 8] = addr_q[SLOT_PAIR0 + 2*p + 1];
  end

  // Writes to mapped address registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < SLOT_N; i++) begin
        addr_q[i] <= ADDR_RST;
      end
    end else if (reg_wr_in && wr_slot[4]) begin
      addr_q[wr_slot[3:0]] <= reg_wdata_in;
    end
  end

  // Routing only outside Ethernet operation; zero key turns scrambling off
  assign route_active = route_en_in && (op_mode_in != MODE_ETHERNET);
  assign enc_on = enc_en_in && (key_in != KEY_OFF);

  // Read mux; unmapped numbers read zero
  assign rd_value = rd_slot[4] ? addr_q[rd_slot[3:0]] :
                    (reg_num_in == REG_STATUS) ? status : 8'h00;

  // Read data held until the next read
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_value;
    end
  end

  // Receive path

  rra_rx_t rstate; // Receive frame state
  rra_rx_t next_rstate;
  rra_org_t ostate; // Origination state
  rra_org_t next_ostate;
  logic [7:0] rx_plain; // Descrambled receive byte
  logic [7:0] src_q; // Received source address
  logic [7:0] dst_q; // Received destination address
  logic hdr_last_q; // Frame ended on its destination byte
  logic hit; // Address pair recognised
  logic to_local; // Recognised and meant for us
  logic decide; // Destination byte arrives this cycle
  logic relay_go; // Start a relay header
  logic [1:0] rl_step; // Relay header progress
  logic [1:0] tag_in; // Route of the arriving byte
  logic [DLY_W-1:0] dly [RX_DELAY]; // Two-byte delay for header room
  logic relay_busy; // Radio transmitter owned by a relay

  rra_scrambler u_rx_scr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .key_in(key_in),
    .enc_on_in(enc_on),
    .start_in(rstate == RX_IDLE),
    .step_in(rx_valid_in),
    .byte_in(rx_data_in),
    .byte_out(rx_plain)
  );

  rra_pair_match u_match (
    .snd_in(snd_vec),
    .tgt_in(tgt_vec),
    .src_in(src_q),
    .dst_in(rx_plain),
    .hit_out(hit)
  );

  assign decide = (rstate == RX_DST) && rx_valid_in;
  assign to_local = hit && (rx_plain == local_addr);
  // Relay only if our own transmission is not in progress
  assign relay_go = decide && hit && !to_local && (ostate == O_IDLE);

  // Route tag for payload bytes; dropped bytes carry none
  assign tag_in = !rx_valid_in ? TAG_NONE :
    ((rstate == RX_IDLE && !route_active) || rstate == RX_SER) ? TAG_SER :
    (rstate == RX_RLY) ? TAG_RLY : TAG_NONE;

  assign relay_busy = (rstate == RX_RLY) || (rl_step != RL_NONE) ||
                      (dly[0][DLY_TAG +: 2] == TAG_RLY) ||
                      (dly[1][DLY_TAG +: 2] == TAG_RLY);

  // Receive frame sequencing
  always_comb begin
    next_rstate = rstate;
    case (rstate)
      RX_IDLE: begin
        if (rx_valid_in && !rx_last_in) begin
          next_rstate = route_active ? RX_DST : RX_SER;
        end
      end
      RX_DST: begin
        if (rx_valid_in) begin
          if (rx_last_in) begin
            next_rstate = RX_IDLE;
          end else if (hit && to_local) begin
            next_rstate = RX_SER;
          end else if (relay_go) begin
            next_rstate = RX_RLY;
          end else begin
            next_rstate = RX_DROP;
          end
        end
      end
      RX_SER, RX_RLY, RX_DROP: begin
        if (rx_valid_in && rx_last_in) begin
          next_rstate = RX_IDLE;
        end
      end
      default: next_rstate = RX_IDLE;
    endcase
  end

  // Receive state, captured header and relay header steps
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rstate <= RX_IDLE;
      src_q <= ADDR_RST;
      dst_q <= ADDR_RST;
      hdr_last_q <= 1'b0;
      rl_step <= RL_NONE;
    end else begin
      rstate <= next_rstate;
      if (rstate == RX_IDLE && rx_valid_in) begin
        src_q <= rx_plain;
      end
      if (decide) begin
        dst_q <= rx_plain;
        hdr_last_q <= rx_last_in;
      end
      rl_step <= relay_go ? RL_SRC :
                 (rl_step == RL_SRC) ? RL_DST : RL_NONE;
    end
  end

  // Delay line gives the relay header two free cycles
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < RX_DELAY; i++) begin
        dly[i] <= '0;
      end
    end else begin
      dly[0] <= {tag_in, rx_last_in, rx_plain};
      dly[1] <= dly[0];
    end
  end

  // Origination of host frames

  logic o_first_q; // Next host byte opens an unaddressed frame
  logic host_take; // Host byte taken this cycle
  logic host_start; // Host frame may begin

  assign host_take = (ostate == O_DATA) && host_valid_in && host_ready_out;
  assign host_start = host_valid_in && !relay_busy && (rstate != RX_DST);

  always_comb begin
    next_ostate = ostate;
    case (ostate)
      O_IDLE: begin
        if (host_start) begin
          next_ostate = route_active ? O_SRC : O_DATA;
        end
      end
      O_SRC: next_ostate = O_DST;
      O_DST: next_ostate = O_DATA;
      O_DATA: begin
        if (host_take && host_last_in) begin
          next_ostate = O_IDLE;
        end
      end
      default: next_ostate = O_IDLE;
    endcase
  end

  // Host handshake state; ready only while payload is being passed
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ostate <= O_IDLE;
      host_ready_out <= 1'b0;
      o_first_q <= 1'b0;
    end else begin
      ostate <= next_ostate;
      host_ready_out <= (next_ostate == O_DATA);
      if (ostate == O_IDLE && next_ostate == O_DATA) begin
        o_first_q <= 1'b1;
      end else if (host_take) begin
        o_first_q <= 1'b0;
      end
    end
  end

  // Transmit selection

  logic rly_byte; // Relay payload leaves the delay line
  logic tx_go; // Radio byte this cycle
  logic tx_first; // First byte of a radio frame
  logic tx_last; // Last byte of a radio frame
  logic [7:0] tx_plain; // Byte before scrambling
  logic [7:0] tx_enc; // Byte after scrambling
  logic [7:0] tx_plain_q; // Registered plain byte, watched by checks

  assign rly_byte = dly[1][DLY_TAG +: 2] == TAG_RLY;
  assign tx_go = (rl_step != RL_NONE) || rly_byte || (ostate == O_SRC) ||
                 (ostate == O_DST) || host_take;
  assign tx_first = (rl_step == RL_SRC) || (ostate == O_SRC) ||
                    (host_take && o_first_q);
  // Relay header: our address replaces the source, then destination
  assign tx_plain = (rl_step == RL_SRC) ? local_addr :
                    (rl_step == RL_DST) ? dst_q :
                    rly_byte ? dly[1][7:0] :
                    (ostate == O_SRC) ? local_addr :
                    (ostate == O_DST) ? dest_addr : host_data_in;
  assign tx_last = (rl_step == RL_SRC) ? 1'b0 :
                   (rl_step == RL_DST) ? hdr_last_q :
                   rly_byte ? dly[1][DLY_LAST] :
                   (ostate == O_DATA) && host_last_in;

  rra_scrambler u_tx_scr (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .key_in(key_in),
    .enc_on_in(enc_on),
    .start_in(tx_first),
    .step_in(tx_go),
    .byte_in(tx_plain),
    .byte_out(tx_enc)
  );

  // Output registers for radio and serial streams
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rad_valid_out <= 1'b0;
      rad_data_out <= 8'h00;
      rad_last_out <= 1'b0;
      tx_plain_q <= 8'h00;
      ser_valid_out <= 1'b0;
      ser_data_out <= 8'h00;
      ser_last_out <= 1'b0;
    end else begin
      rad_valid_out <= tx_go;
      rad_data_out <= tx_enc;
      rad_last_out <= tx_go && tx_last;
      tx_plain_q <= tx_plain;
      ser_valid_out <= dly[1][DLY_TAG +: 2] == TAG_SER;
      ser_data_out <= dly[1][7:0];
      ser_last_out <= (dly[1][DLY_TAG +: 2] == TAG_SER) && dly[1][DLY_LAST];
    end
  end

  // Status: bit0 routing, bit1 scrambling, bit2 relay, bit3 host frame
  assign status = {4'h0, ostate != O_IDLE, relay_busy, enc_on, route_active};

  // Checks

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_hdr(logic [7:0] d);
    rad_valid_out && tx_plain_q == local_addr ##1
    rad_valid_out && tx_plain_q == d;
  endsequence

  a_relay_hdr_order: assert property (
    relay_go |-> ##2 s_hdr(dst_q))
    else $error("relay header not local then destination");

  a_orig_hdr_order: assert property (
    (ostate == O_SRC) |=> s_hdr(dest_addr))
    else $error("originated header not local then destination");

  a_unmatched_drop: assert property (
    (decide && !hit && !rx_last_in) |=> (rstate == RX_DROP))
    else $error("unmatched frame not dropped");

  a_drop_silent: assert property (
    (rstate == RX_DROP && rx_valid_in) |-> ##3 !ser_valid_out)
    else $error("dropped byte reached serial output");

  a_local_serial: assert property (
    (decide && to_local && !rx_last_in) |=> (rstate == RX_SER))
    else $error("frame for local address not sent to serial");

  a_serial_payload: assert property (
    (rstate == RX_SER && rx_valid_in) |-> ##3
      (ser_valid_out && ser_data_out == $past(rx_plain, 3)))
    else $error("serial byte missing or changed");

  a_eth_no_hdr: assert property (
    (ostate == O_IDLE && host_start && !route_active) |=>
      (ostate == O_DATA) ##1
      (rad_valid_out && tx_plain_q == $past(host_data_in)))
    else $error("address header added outside routing modes");

  a_zero_key_plain: assert property (
    (rad_valid_out && $past(key_in) == KEY_OFF) |->
      (rad_data_out == tx_plain_q))
    else $error("zero key still scrambled a byte");

  a_key_first_byte: assert property (
    (ostate == O_SRC && enc_on && $stable(key_in)) |=>
      (rad_data_out == (local_addr ^ key_in[7:0])))
    else $error("first byte not scrambled with key low byte");

  a_reg_readback: assert property (
    (reg_wr_in && wr_slot[4]) ##1
      (reg_rd_in && !reg_wr_in && reg_num_in == $past(reg_num_in)) |=>
      (reg_rdata_out == $past(reg_wdata_in, 2)))
    else $error("address register readback mismatch");
endmodule : rra_router
`default_nettype wire

// ==== hdl/rra_scrambler.sv ====
/*
  Byte scrambler with a 24-bit key that rotates by one byte per byte.
  Assumes one byte per step_in pulse and start_in on each frame's first.
*/
`timescale 1ns/1ns
`default_nettype none
module rra_scrambler (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Key control
  input wire logic [rra_pkg::KEY_W-1:0] key_in,
  input wire logic enc_on_in,
  // Byte stream
  input wire logic start_in,
  input wire logic step_in,
  input wire logic [7:0] byte_in,
  output logic [7:0] byte_out
);
  import rra_pkg::*;

  logic [KEY_W-1:0] rot; // Key position for the next byte
  logic [KEY_W-1:0] cur_key; // Key position for this byte
  logic [KEY_W-1:0] next_rot; // Key rotated by one byte

  // A frame always restarts from the configured key
  assign cur_key = start_in ? key_in : rot;
  assign next_rot = {cur_key[7:0], cur_key[KEY_W-1:8]};
  assign byte_out = enc_on_in ? (byte_in ^ cur_key[7:0]) : byte_in;

  // Advance the rotation on each byte taken
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rot <= KEY_OFF;
    end else if (step_in) begin
      rot <= next_rot;
    end
  end
endmodule : rra_scrambler
`default_nettype wire

// ==== tb/rra_peer_model.sv ====
/*
  Peer radio modem: sends scrambled frames into the router's receive
  side and unscrambles what the router sends out by radio.
  Assumes the bench calls send_frame just after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module rra_peer_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Key setting shared with the router
  input wire logic enc_on_in,
  input wire logic [23:0] key_in,
  // Radio stream from the router
  input wire logic rad_valid_in,
  input wire logic [7:0] rad_data_in,
  input wire logic rad_last_in,
  // Radio stream into the router
  output logic rx_valid_out,
  output logic [7:0] rx_data_out,
  output logic rx_last_out
);
  logic [8:0] got_rad[$]; // Unscrambled {last, byte} heard on radio
  logic [23:0] rx_key; // Running key inside an incoming frame
  logic rx_first; // Next radio byte opens a frame
  logic busy; // A frame is being sent
  wire scr_on = enc_on_in && key_in != 24'h000000;

  // Key moves on by one byte per byte
  function automatic logic [23:0] rot(input logic [23:0] k);
    return {k[7:0], k[23:8]};
  endfunction : rot

  // Quiet line
  initial begin
    rx_valid_out = 1'b0;
    rx_last_out = 1'b0;
    rx_data_out = 8'h00;
    busy = 1'b0;
  end

  // Idle data changes every cycle so no stale byte looks valid
  always @(posedge clk_in) begin
    if (!busy) rx_data_out <= rx_data_out + 8'h3b;
  end

  // Unscramble each radio byte with the key the router should use
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_first <= 1'b1;
      rx_key <= 24'h000000;
    end else if (rad_valid_in === 1'b1) begin
      got_rad.push_back({rad_last_in, rad_data_in ^ (scr_on ?
        (rx_first ? key_in[7:0] : rx_key[7:0]) : 8'h00)});
      rx_key <= rot(rx_first ? key_in : rx_key);
      rx_first <= rad_last_in;
    end
  end

  // Send one frame, one byte per cycle, scrambled from its first byte
  task automatic send_frame(input logic [7:0] q[$]);
    logic [23:0] k;
    k = key_in;
    busy = 1'b1;
    foreach (q[i]) begin
      rx_valid_out = 1'b1;
      rx_data_out = q[i] ^ (scr_on ? k[7:0] : 8'h00);
      rx_last_out = (i == q.size() - 1);
      k = rot(k);
      @(posedge clk_in);
      #1;
    end
    rx_valid_out = 1'b0;
    rx_last_out = 1'b0;
    rx_data_out = ~rx_data_out;
    busy = 1'b0;
  endtask : send_frame
endmodule : rra_peer_model
`default_nettype wire

// ==== tb/test_radio_repeater_address_router.sv ====
/*
  Self-checking bench for the address router: register access, host
  frames, received frames for each pair, relay, drop and mode handling.
  Assumes the peer model in rra_peer_model.sv and the rra_pkg constants.
*/
`timescale 1ns/1ns
`default_nettype none
module test_radio_repeater_address_router;
  import rra_pkg::*;
  logic clk_in, rst_in, reg_wr_in, reg_rd_in, route_en_in, enc_en_in;
  logic [7:0] reg_num_in, reg_wdata_in, reg_rdata_out, host_data_in;
  logic [1:0] op_mode_in;
  logic [KEY_W-1:0] key_in;
  logic host_valid_in, host_last_in, host_ready_out;
  logic rx_valid_in, rx_last_in, rad_valid_out, rad_last_out;
  logic [7:0] rx_data_in, rad_data_out, ser_data_out;
  logic ser_valid_out, ser_last_out;
  int n_mismatch, n_checks, n_cycles;
  logic [31:0] seed; // Random source state
  logic [7:0] rm [0:255]; // Register model
  logic [8:0] exp_ser[$], exp_rad[$], got_ser[$]; // {last, byte}
  wire routing = route_en_in && op_mode_in != MODE_ETHERNET;
  localparam logic [7:0] SND_NUM [0:3] = '{REG_P1_SND, REG_P2_SND,
    REG_P3_SND, REG_P4_SND};
  localparam logic [7:0] TGT_NUM [0:3] = '{REG_P1_TGT, REG_P2_TGT,
    REG_P3_TGT, REG_P4_TGT};
  localparam logic [7:0] PS [0:3] = '{8'haa, 8'hbb, 8'hcc, 8'hdd};
  localparam logic [7:0] PT [0:3] = '{8'h11, 8'h44, 8'h11, 8'h66};
  // {route enable, mode, scramble enable, key}
  localparam logic [27:0] CFG [0:4] = '{{1'b1, MODE_TRANSP, 1'b1,
    24'ha1b2c3}, {1'b1, MODE_MODBUS, 1'b0, 24'ha1b2c3}, {1'b1,
    MODE_MIRROR, 1'b1, 24'h000000}, {1'b1, MODE_ETHERNET, 1'b1,
    24'h3c1e27}, {1'b0, MODE_TRANSP, 1'b1, 24'h3c1e27}};

  rra_router i_rra_router (.clk_in(clk_in), .rst_in(rst_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_num_in(reg_num_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .route_en_in(route_en_in), .op_mode_in(op_mode_in),
    .enc_en_in(enc_en_in), .key_in(key_in), .host_valid_in(host_valid_in),
    .host_data_in(host_data_in), .host_last_in(host_last_in),
    .host_ready_out(host_ready_out), .rx_valid_in(rx_valid_in),
    .rx_data_in(rx_data_in), .rx_last_in(rx_last_in),
    .rad_valid_out(rad_valid_out), .rad_data_out(rad_data_out),
    .rad_last_out(rad_last_out), .ser_valid_out(ser_valid_out),
    .ser_data_out(ser_data_out), .ser_last_out(ser_last_out));

  rra_peer_model i_rra_peer_model (.clk_in(clk_in), .rst_in(rst_in),
    .enc_on_in(enc_en_in), .key_in(key_in), .rad_valid_in(rad_valid_out),
    .rad_data_in(rad_data_out), .rad_last_in(rad_last_out),
    .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
    .rx_last_out(rx_last_in));

  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Collect serial output; cut a hang short
  always @(posedge clk_in) begin
    if (ser_valid_out === 1'b1) got_ser.push_back({ser_last_out,
      ser_data_out});
    n_cycles++;
    if (n_cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // Linear feedback shift register random byte
  function automatic logic [7:0] rnd8();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd8

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask : step

  task automatic check(input string what, input logic [8:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] n, d);
    step();
    reg_wr_in = 1'b1;
    reg_num_in = n;
    reg_wdata_in = d;
    step();
    reg_wr_in = 1'b0;
    if (n >= REG_LOCAL && n < REG_STATUS) rm[n] = d;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] n);
    reg_rd_in = 1'b1;
    reg_num_in = n;
    step();
    reg_rd_in = 1'b0;
    step();
    check("register", {1'b0, (n >= REG_LOCAL && n < REG_STATUS) ? rm[n] :
      (n == REG_STATUS) ? {6'h00, enc_en_in && key_in != KEY_OFF, routing}
      : 8'h00}, {1'b0, reg_rdata_out});
  endtask : reg_read

  // Host frame of len random bytes, waiting on ready for each
  task automatic send_host(input int len);
    int w;
    if (routing) begin
      exp_rad.push_back({1'b0, rm[REG_LOCAL]});
      exp_rad.push_back({1'b0, rm[REG_DEST]});
    end
    for (int i = 0; i < len; i++) begin
      host_valid_in = 1'b1;
      host_data_in = rnd8();
      host_last_in = (i == len - 1);
      exp_rad.push_back({host_last_in, host_data_in});
      w = 0;
      do begin
        @(posedge clk_in);
        w++;
      end while (host_ready_out !== 1'b1 && w < 50);
      #1;
    end
    host_valid_in = 1'b0;
    host_last_in = 1'b0;
    repeat (10) step();
  endtask : send_host

  // Radio frame src, dst, len payload bytes (len -1: source byte only)
  task automatic send_rx(input logic [7:0] s, d, input int len);
    logic [7:0] q[$];
    logic hit;
    hit = 1'b0;
    q = '{s, d};
    for (int i = 0; i < len; i++) q.push_back(rnd8());
    if (len < 0) void'(q.pop_back());
    for (int p = 0; p < 4; p++) begin
      if (rm[SND_NUM[p]] == s && rm[TGT_NUM[p]] == d) hit = 1'b1;
    end
    if (!routing) begin
      foreach (q[i]) exp_ser.push_back({i == q.size() - 1, q[i]});
    end else if (hit && q.size() > 1 && d == rm[REG_LOCAL]) begin
      for (int i = 2; i < q.size(); i++) begin
        exp_ser.push_back({i == q.size() - 1, q[i]});
      end
    end else if (hit && q.size() > 1) begin
      exp_rad.push_back({1'b0, rm[REG_LOCAL]});
      for (int i = 1; i < q.size(); i++) begin
        exp_rad.push_back({i == q.size() - 1, q[i]});
      end
    end
    i_rra_peer_model.send_frame(q);
    repeat (10) step();
  endtask : send_rx

  // Compare both output streams with the model and clear them
  task automatic compare_all(input int t);
    check("serial count", 9'(exp_ser.size()), 9'(got_ser.size()));
    for (int i = 0; i < exp_ser.size() && i < got_ser.size(); i++) begin
      check("serial byte", exp_ser[i], got_ser[i]);
    end
    check("radio count", 9'(exp_rad.size()),
      9'(i_rra_peer_model.got_rad.size()));
    foreach (exp_rad[i]) begin
      if (i < i_rra_peer_model.got_rad.size()) begin
        check("radio byte", exp_rad[i], i_rra_peer_model.got_rad[i]);
      end
    end
    exp_ser.delete();
    got_ser.delete();
    exp_rad.delete();
    i_rra_peer_model.got_rad.delete();
    $display("test config %0d done", t);
  endtask : compare_all

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    seed = 32'h9c5275a6;
    n_mismatch = 0;
    n_checks = 0;
    n_cycles = 0;
    rst_in = 1'b1;
    {reg_wr_in, reg_rd_in, reg_num_in, reg_wdata_in} = 18'h00000;
    {route_en_in, op_mode_in, enc_en_in, key_in} = 28'h0000000;
    {host_valid_in, host_data_in, host_last_in} = 10'h000;
    foreach (rm[i]) rm[i] = ADDR_RST;
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    step();
    // Reset values, random write and read back, unmapped and status
    for (int n = 8'h5a; n <= 8'h64; n++) reg_read(8'(n));
    for (int n = 8'h5a; n <= 8'h64; n++) reg_write(8'(n), rnd8());
    reg_write(8'h70, rnd8());
    for (int n = 8'h5a; n <= 8'h64; n++) reg_read(8'(n));
    reg_read(8'h70);
    reg_write(REG_P4_TGT, rnd8());
    reg_read(REG_P4_TGT);
    $display("test registers done");
    reg_write(REG_LOCAL, 8'h11);
    reg_write(REG_DEST, 8'h33);
    for (int p = 0; p < 4; p++) begin
      reg_write(SND_NUM[p], PS[p]);
      reg_write(TGT_NUM[p], PT[p]);
    end
    // Each mode and key setting: host frame, all pairs, miss, short
    for (int c = 0; c < 5; c++) begin
      {route_en_in, op_mode_in, enc_en_in, key_in} = CFG[c];
      step();
      reg_read(REG_STATUS);
      send_host(3);
      for (int p = 0; p < 4; p++) send_rx(PS[p], PT[p], 2);
      send_rx(8'haa, 8'h44, 2);
      send_rx(8'hbb, 8'h44, -1);
      compare_all(c);
    end
    report_and_stop();
  end
endmodule : test_radio_repeater_address_router
`default_nettype wire
